// ===== verif/dlrm_properties.sv
// Concurrent checks on the mode register link between the two ends.
`timescale 1ns/1ps
module dlrm_properties
    import dlrm_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [5:0] cmdAddr,
    input wire logic [7:0] cmdData,
    input wire logic rdValid,
    input wire logic [7:0] rdData,
    input wire logic burstEnd,
    input wire logic burstWrite,
    input wire logic burstAp,
    input wire logic burst32
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [5:0] rdAddr_q;
    logic prot_q;
    logic [3:0] rt_q;
    // Shadow of the writable refresh bits, so read answers can be judged.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prot_q <= 1'b0;
            rt_q <= 4'h0;
        end else if (cmdValid && cmdWrite) begin
            if (cmdAddr == ADDR_IO && cmdData[IO_REPAIR_PROTECTION_BIT]) begin
                prot_q <= 1'b1;
            end
            if (cmdAddr == ADDR_RT) begin
                rt_q <= {cmdData[6:5],
                    (prot_q && cmdData[4]) ? rt_q[1] : cmdData[4],
                    cmdData[3]};
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (cmdValid && !cmdWrite) begin
            rdAddr_q <= cmdAddr;
        end
    end
    a_read_answer: assert property (cmdValid && !cmdWrite |=> rdValid)
        else $error("read got no answer");
    a_answer_cause: assert property (rdValid |-> $past(cmdValid && !cmdWrite))
        else $error("answer without a read");
    a_cmd_pulse: assert property (cmdValid |=> !cmdValid)
        else $error("command held too long");
    a_burst_pulse: assert property (burstEnd |=> !burstEnd)
        else $error("burst end held too long");
    a_rdata_hold: assert property (!rdValid |-> $stable(rdData))
        else $error("read data moved");
    a_prot_sticky: assert property (rdValid && rdAddr_q == ADDR_IO
        |-> rdData[IO_REPAIR_PROTECTION_BIT] == prot_q) else $error("protection bit wrong");
    a_repair_refused: assert property (rdValid && rdAddr_q == ADDR_RT
        |-> rdData[RT_REPAIR_ENTRY_BIT] == rt_q[1]) else $error("repair entry wrong");
    a_rt_write_bits: assert property (rdValid && rdAddr_q == ADDR_RT
        |-> {rdData[6:5], rdData[3]} == {rt_q[3:2], rt_q[0]})
        else $error("refresh write bits wrong");
endmodule // dlrm_properties

// ===== verif/tb.sv
// Self-checking bench for the controller and channel joined by the link.
`timescale 1ns/1ps
module tb;
    import dlrm_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] sensorRate = 3'h3;
    logic sensorDerate = 1'b0;
    logic initDone = 1'b0;
    logic peerPucal = 1'b1;
    logic peerPucalValid = 1'b0;
    logic [31:0] prdata, r, v;
    logic pready, pslverr, err, pucalValue, pucalValid, calStart;
    logic pullupCal, wrPostLong, readInvEn, writeInvEn, wlSetB;
    logic repairProtect, repairMode, srAbortEn, prechargeStart;
    logic [2:0] pulldownDrive, pr, rw;
    logic [1:0] thermalOffset;
    logic [31:0] seed = 32'hA97DA6A8;
    logic [7:0] m;
    logic [7:0] cp [2] = '{IO_RESET, IO_RESET};
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    dlrm_if link();
    dlrm_controller u_dlrm_controller (.*);
    dlrm_device u_dlrm_device (.*);
    dlrm_properties u_dlrm_properties (.mclk(mclk), .sys_rst(sys_rst),
        .cmdValid(link.cmdValid), .cmdWrite(link.cmdWrite),
        .cmdAddr(link.cmdAddr), .cmdData(link.cmdData),
        .rdValid(link.rdValid), .rdData(link.rdData),
        .burstEnd(link.burstEnd), .burstWrite(link.burstWrite),
        .burstAp(link.burstAp), .burst32(link.burst32));
    always #2.5 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] refi(input int c);
        case (c)
            1: return REFI_BASE_DEFAULT << 2;
            2: return REFI_BASE_DEFAULT << 1;
            3: return REFI_BASE_DEFAULT;
            4: return REFI_BASE_DEFAULT >> 1;
            default: return REFI_BASE_DEFAULT >> 2;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk);
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // A command sent while busy is dropped, so always wait for idle first.
    task automatic idle();
        do apb(1'b0, APB_CMD, 32'h0);
        while (r[CMD_BUSY] !== 1'b0);
    endtask
    task automatic mr(input logic w, input logic [5:0] a, input logic [7:0] d);
        idle();
        apb(1'b1, APB_CMD, {15'h0, w, 2'h0, a, d});
        idle();
        m = r[7:0];
        repeat (3) @(posedge mclk);
    endtask
    task automatic cal(input logic p, input int e);
        peerPucal <= p;
        apb(1'b1, APB_CAL, 32'h1);
        n = 0;
        repeat (4) begin
            @(posedge mclk);
            if (calStart === 1'b1) n++;
        end
        chk("cal", n, e);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        mr(1'b0, ADDR_IO, 8'h00);
        chk("io rst", m, IO_RESET);
        mr(1'b0, ADDR_RT, 8'h00);
        chk("rt rst", m, {5'h0, RATE_RESET});
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", err, 1'b1);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            mr(1'b1, ADDR_SPC, {v[9:8], 6'h0});
            mr(1'b1, ADDR_IO, v[7:0] & 8'hFB);
            cp[v[8]] = v[7:0] & 8'hFB;
            cp[~v[8]][0] = v[0];
            mr(1'b0, ADDR_IO, 8'h00);
            chk("io rd", m, cp[v[8]]);
            chk("io act", {writeInvEn, readInvEn, pulldownDrive, repairProtect,
                wrPostLong, pullupCal}, cp[v[9]]);
        end
        for (int k = 0; k < 7; k++) begin
            v = rnd();
            apb(1'b1, APB_LAT, {27'h0, v[4:3], k[2:0]});
            v[18:8] = v[5] ? FREQ_HI[k] + {10'h0, v[6]} : v[18:8];
            apb(1'b1, APB_FREQ, {21'h0, v[18:8]});
            apb(1'b0, APB_LAT, 32'h0);
            chk("rl", r[7:0], v[3] ? RL_INV[k] : RL_PLAIN[k]);
            chk("wl", r[15:8], v[4] ? WL_B[k] : WL_A[k]);
            chk("band", r[LAT_BAD],
                v[18:8] <= FREQ_LO[k] || v[18:8] > FREQ_HI[k]);
            apb(1'b0, APB_FREQ, 32'h0);
            chk("freq", r, {21'h0, v[18:8]});
        end
        mr(1'b1, ADDR_SPC, 8'hC0);
        for (int k = 0; k < 9; k++) begin
            v = rnd();
            rw = (v[2:0] > LAT_TOP) ? LAT_TOP : v[2:0];
            mr(1'b1, ADDR_LAT, {1'b0, v[6], 3'h0, v[2:0]});
            mr(1'b0, ADDR_LAT, 8'h00);
            chk("lat rd", m, {1'b0, v[6], 3'h0, v[2:0]});
            chk("wls", wlSetB, v[6]);
            v[7] = (k % 3 == 0) ? v[5] : (k % 3 == 2);
            apb(1'b1, APB_BURST, {29'h0, v[7], 1'b1, k % 3 == 0});
            do @(posedge mclk);
            while (link.burstEnd !== 1'b1);
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (prechargeStart !== 1'b1 && n < 80);
            chk("pre", n, 1 + ((k % 3 == 0) ? NWR_TBL[rw] : READ_TO_PRECHARGE_COUNT_TBL[rw]
                + (v[7] ? BL32_EXTRA : 6'h0)));
        end
        initDone <= 1'b1;
        pr = RATE_RESET;
        for (int c = 0; c < 8; c++) begin
            sensorRate <= c[2:0];
            mr(1'b0, ADDR_RT, 8'h00);
            chk("rate", m[2:0], c[2:0]);
            chk("flag", m[RT_TUF], c[2:0] != pr);
            pr = c[2:0];
            apb(1'b0, APB_REFR, 32'h0);
            chk("unsafe", r[REF_UNSAFE], c == 0 || c == 7);
            if (c > 0 && c < 7) chk("refi", r[15:0], refi(c));
        end
        mr(1'b0, ADDR_RT, 8'h00);
        chk("flag clr", m[RT_TUF], 1'b0);
        sensorDerate <= 1'b1;
        mr(1'b0, ADDR_RT, 8'h00);
        chk("derate", m[2:0], RATE_DERATE);
        mr(1'b1, ADDR_RT, 8'h97);
        chk("ppr in", repairMode, 1'b1);
        mr(1'b1, ADDR_RT, 8'h00);
        chk("ppr out", repairMode, 1'b0);
        mr(1'b1, ADDR_IO, 8'h04);
        mr(1'b1, ADDR_IO, 8'h00);
        chk("prot", repairProtect, 1'b1);
        mr(1'b1, ADDR_RT, 8'h7F);
        chk("ppr refused", repairMode, 1'b0);
        chk("sra", srAbortEn, 1'b1);
        chk("ofs", thermalOffset, 2'h3);
        mr(1'b0, ADDR_RT, 8'h00);
        chk("rt bits", m[6:3], 4'hD);
        chk("pu val", {pucalValid, pucalValue}, 2'h2);
        peerPucalValid <= 1'b1;
        cal(1'b0, 1);
        cal(1'b1, 0);
        // Protection survives every write, so only a reset may clear it.
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        mr(1'b0, ADDR_IO, 8'h00);
        chk("prot rst", m[IO_REPAIR_PROTECTION_BIT], 1'b0);
        chk("prot out", repairProtect, 1'b0);
        test_done();
    end
endmodule // tb

// ===== verilog/dlrm_controller.sv
// Controller end: APB registers driving mode register and burst commands.
`timescale 1ns/1ps
module dlrm_controller #(
    parameter logic [15:0] REFI_BASE = dlrm_pkg::REFI_BASE_DEFAULT
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic peerPucal,
    input wire logic peerPucalValid,
    output logic pucalValue,
    output logic pucalValid,
    output logic calStart,
    dlrm_if.ctl link
);
    import dlrm_pkg::*;

    logic cmdValid_q;
    logic cmdWrite_q;
    logic [5:0] cmdAddr_q;
    logic [7:0] cmdData_q;
    logic busy_q;
    logic rtPending_q;
    logic [7:0] lastRd_q;
    logic [2:0] row_q;
    logic dbi_q;
    logic wlb_q;
    logic [10:0] freq_q;
    logic [2:0] rate_q;
    logic burstEnd_q;
    logic [2:0] burst_q;
    logic setup;
    logic wrDone;
    logic mapped;
    logic [7:0] rl;
    logic [7:0] wl;
    logic bandBad;
    logic [15:0] refi;

    assign setup = psel && !penable && !pready;
    assign wrDone = psel && penable && pready && pwrite;
    assign mapped = paddr inside {APB_CMD, APB_LAT, APB_FREQ, APB_BURST,
        APB_REFR, APB_CAL};
    assign rl = dbi_q ? RL_INV[row_q] : RL_PLAIN[row_q];
    assign wl = wlb_q ? WL_B[row_q] : WL_A[row_q];
    assign bandBad = (freq_q <= FREQ_LO[row_q]) ||
        (freq_q > FREQ_HI[row_q]);

    always_comb begin
        unique case (rate_q)
            3'h1: refi = REFI_BASE << 2;
            3'h2: refi = REFI_BASE << 1;
            3'h4: refi = REFI_BASE >> 1;
            3'h5, 3'h6: refi = REFI_BASE >> 2;
            default: refi = REFI_BASE;
        endcase
    end

    // One access cycle per transfer; unmapped offsets answer with pslverr.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                unique case (paddr)
                    APB_CMD: prdata <= {busy_q, 23'h000000, lastRd_q};
                    APB_LAT: prdata <= {15'h0000, bandBad, wl, rl};
                    APB_FREQ: prdata <= {21'h000000, freq_q};
                    APB_REFR: prdata <= {15'h0000,
                        rate_q == RATE_BAD_LO || rate_q == RATE_BAD_HI,
                        refi};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // A new command written while busy is dropped.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmdValid_q <= 1'b0;
            cmdWrite_q <= 1'b0;
            cmdAddr_q <= 6'h00;
            cmdData_q <= 8'h00;
            busy_q <= 1'b0;
            rtPending_q <= 1'b0;
        end else begin
            cmdValid_q <= 1'b0;
            if (wrDone && paddr == APB_CMD && !busy_q) begin
                cmdValid_q <= 1'b1;
                cmdWrite_q <= pwdata[CMD_WR];
                cmdAddr_q <= pwdata[13:8];
                cmdData_q <= pwdata[7:0];
                busy_q <= !pwdata[CMD_WR];
                rtPending_q <= !pwdata[CMD_WR] && pwdata[13:8] == ADDR_RT;
            end else if (link.rdValid) begin
                busy_q <= 1'b0;
                rtPending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lastRd_q <= 8'h00;
            rate_q <= RATE_RESET;
        end else if (link.rdValid && busy_q) begin
            lastRd_q <= link.rdData;
            if (rtPending_q) begin
                rate_q <= link.rdData[2:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            row_q <= 3'h0;
            dbi_q <= 1'b0;
            wlb_q <= 1'b0;
            freq_q <= 11'h000;
        end else if (wrDone && paddr == APB_LAT) begin
            row_q <= (pwdata[2:0] > LAT_TOP) ? LAT_TOP : pwdata[2:0];
            dbi_q <= pwdata[LAT_DBI];
            wlb_q <= pwdata[LAT_WLB];
        end else if (wrDone && paddr == APB_FREQ) begin
            freq_q <= pwdata[10:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            burstEnd_q <= 1'b0;
            burst_q <= 3'h0;
        end else begin
            burstEnd_q <= wrDone && paddr == APB_BURST;
            if (wrDone && paddr == APB_BURST) begin
                burst_q <= pwdata[2:0];
            end
        end
    end

    // Calibration starts only if both channels hold the same pull-up point; otherwise the request is dropped.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pucalValue <= IO_RESET[IO_PUCAL];
            pucalValid <= 1'b0;
            calStart <= 1'b0;
        end else begin
            if (wrDone && paddr == APB_CMD && !busy_q && pwdata[CMD_WR] &&
                pwdata[13:8] == ADDR_IO) begin
                pucalValue <= pwdata[IO_PUCAL];
                pucalValid <= 1'b1;
            end
            calStart <= wrDone && paddr == APB_CAL && pwdata[0] &&
                pucalValid && peerPucalValid &&
                pucalValue == peerPucal;
        end
    end

    assign link.cmdValid = cmdValid_q;
    assign link.cmdWrite = cmdWrite_q;
    assign link.cmdAddr = cmdAddr_q;
    assign link.cmdData = cmdData_q;
    assign link.burstEnd = burstEnd_q;
    assign link.burstWrite = burst_q[BUR_WR];
    assign link.burstAp = burst_q[BUR_AP];
    assign link.burst32 = burst_q[BUR_32];
endmodule // dlrm_controller

// ===== verilog/dlrm_device.sv
// Memory channel end: mode registers, set points and auto-precharge timing.
`timescale 1ns/1ps
module dlrm_device #(
    parameter int DENSITY_GB = dlrm_pkg::DENSITY_DEFAULT
) (
    input wire logic mclk,
    input wire logic sys_rst,
    dlrm_if.dev link,
    input wire logic [2:0] sensorRate,
    input wire logic sensorDerate,
    input wire logic initDone,
    output logic pullupCal,
    output logic wrPostLong,
    output logic [2:0] pulldownDrive,
    output logic readInvEn,
    output logic writeInvEn,
    output logic wlSetB,
    output logic repairProtect,
    output logic repairMode,
    output logic srAbortEn,
    output logic [1:0] thermalOffset,
    output logic prechargeStart
);
    import dlrm_pkg::*;

    logic [7:0] ioCopy_q [2];
    logic [7:0] latCopy_q [2];
    logic [7:0] spc_q;
    logic pucal_q;
    logic repair_protection_bit_q;
    logic [2:0] rate_q;
    logic [2:0] rate_d;
    logic [2:0] lastRate_q;
    logic tuf_q;
    logic repair_entry_bit_q;
    logic sra_q;
    logic [1:0] ofs_q;
    logic [5:0] apCnt_q;
    logic apBusy_q;
    logic rdValid_q;
    logic [7:0] rdData_q;
    logic wsp;
    logic osp;
    logic isWr;
    logic isRd;
    logic [2:0] row;
    logic [7:0] rtRead;

    assign wsp = spc_q[SPC_WSP];
    assign osp = spc_q[SPC_OSP];
    assign isWr = link.cmdValid && link.cmdWrite;
    assign isRd = link.cmdValid && !link.cmdWrite;
    assign row = (latCopy_q[osp][2:0] > LAT_TOP) ? LAT_TOP :
        latCopy_q[osp][2:0];
    // A change not yet folded into the flag is still reported as one.
    assign rtRead = {tuf_q || (rate_q != lastRate_q), ofs_q, repair_entry_bit_q, sra_q,
        rate_q};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            spc_q <= SPC_RESET;
        end else if (isWr && link.cmdAddr == ADDR_SPC) begin
            spc_q <= link.cmdData;
        end
    end

    // Only the copy picked by the write set point is touched.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ioCopy_q[0] <= IO_RESET;
            ioCopy_q[1] <= IO_RESET;
            latCopy_q[0] <= LAT_RESET;
            latCopy_q[1] <= LAT_RESET;
        end else if (isWr && link.cmdAddr == ADDR_IO) begin
            ioCopy_q[wsp] <= link.cmdData;
        end else if (isWr && link.cmdAddr == ADDR_LAT) begin
            latCopy_q[wsp] <= link.cmdData;
        end
    end

    // The pull-up point and protection bit have a single copy each.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pucal_q <= IO_RESET[IO_PUCAL];
        end else if (isWr && link.cmdAddr == ADDR_IO) begin
            pucal_q <= link.cmdData[IO_PUCAL];
        end
    end

    // Software can never clear protection; only reset does.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            repair_protection_bit_q <= IO_RESET[IO_REPAIR_PROTECTION_BIT];
        end else if (isWr && link.cmdAddr == ADDR_IO &&
                     link.cmdData[IO_REPAIR_PROTECTION_BIT]) begin
            repair_protection_bit_q <= 1'b1;
        end
    end

    // Writable bits of the refresh register; the rest are dropped.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            repair_entry_bit_q <= 1'b0;
            sra_q <= 1'b0;
            ofs_q <= 2'h0;
        end else if (isWr && link.cmdAddr == ADDR_RT) begin
            sra_q <= link.cmdData[RT_SRA];
            ofs_q <= link.cmdData[RT_OFS_LO +: 2];
            if (!(repair_protection_bit_q && link.cmdData[RT_REPAIR_ENTRY_BIT])) begin
                repair_entry_bit_q <= link.cmdData[RT_REPAIR_ENTRY_BIT];
            end
        end
    end

    // Derating takes over the reported code when the sensor asks.
    always_comb begin
        rate_d = rate_q;
        if (initDone) begin
            rate_d = sensorDerate ? RATE_DERATE : sensorRate;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rate_q <= RATE_RESET;
        end else begin
            rate_q <= rate_d;
        end
    end

    // A change landing in the read cycle sets the flag again.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tuf_q <= 1'b0;
            lastRate_q <= RATE_RESET;
        end else if (isRd && link.cmdAddr == ADDR_RT) begin
            lastRate_q <= rate_q;
            tuf_q <= (rate_d != rate_q);
        end else if (rate_q != lastRate_q) begin
            tuf_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdValid_q <= 1'b0;
            rdData_q <= 8'h00;
        end else begin
            rdValid_q <= isRd;
            if (isRd) begin
                unique case (link.cmdAddr)
                    ADDR_IO: rdData_q <= {ioCopy_q[wsp][7:3], repair_protection_bit_q,
                        ioCopy_q[wsp][IO_WRPST], pucal_q};
                    ADDR_LAT: rdData_q <= latCopy_q[wsp];
                    ADDR_RT: rdData_q <= rtRead;
                    ADDR_SPC: rdData_q <= spc_q;
                    default: rdData_q <= 8'h00;
                endcase
            end
        end
    end

    assign link.rdValid = rdValid_q;
    assign link.rdData = rdData_q;

    // The counter restarts on each new auto-precharge burst.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            apCnt_q <= 6'h00;
            apBusy_q <= 1'b0;
            prechargeStart <= 1'b0;
        end else begin
            prechargeStart <= 1'b0;
            if (link.burstEnd && link.burstAp) begin
                apBusy_q <= 1'b1;
                if (link.burstWrite) begin
                    apCnt_q <= NWR_TBL[row];
                end else if (link.burst32) begin
                    apCnt_q <= READ_TO_PRECHARGE_COUNT_TBL[row] + BL32_EXTRA;
                end else begin
                    apCnt_q <= READ_TO_PRECHARGE_COUNT_TBL[row];
                end
            end else if (apBusy_q) begin
                apCnt_q <= apCnt_q - 6'h01;
                if (apCnt_q == 6'h01) begin
                    apBusy_q <= 1'b0;
                    prechargeStart <= 1'b1;
                end
            end
        end
    end

    // Settings seen by the channel come from the operating copy only.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPostLong <= IO_RESET[IO_WRPST];
            pulldownDrive <= IO_RESET[IO_PULLDOWN_DRIVE_STRENGTH_LO +: 3];
            readInvEn <= IO_RESET[IO_DBIRD];
            writeInvEn <= IO_RESET[IO_DBIWR];
            wlSetB <= LAT_RESET[LAT_WLS];
        end else begin
            wrPostLong <= ioCopy_q[osp][IO_WRPST];
            pulldownDrive <= ioCopy_q[osp][IO_PULLDOWN_DRIVE_STRENGTH_LO +: 3];
            readInvEn <= ioCopy_q[osp][IO_DBIRD];
            writeInvEn <= ioCopy_q[osp][IO_DBIWR];
            wlSetB <= latCopy_q[osp][LAT_WLS];
        end
    end

    // Smaller dies have no abort feature, so the bit is held off.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pullupCal <= IO_RESET[IO_PUCAL];
            repairProtect <= 1'b0;
            repairMode <= 1'b0;
            srAbortEn <= 1'b0;
            thermalOffset <= 2'h0;
        end else begin
            pullupCal <= pucal_q;
            repairProtect <= repair_protection_bit_q;
            repairMode <= repair_entry_bit_q;
            srAbortEn <= sra_q && (DENSITY_GB >= SRA_MIN_DENSITY);
            thermalOffset <= ofs_q;
        end
    end
endmodule // dlrm_device

// ===== verilog/dlrm_if.sv
// Mode register command link between controller and memory channel.
`timescale 1ns/1ps
interface dlrm_if;
    logic cmdValid;
    logic cmdWrite;
    logic [5:0] cmdAddr;
    logic [7:0] cmdData;
    logic rdValid;
    logic [7:0] rdData;
    logic burstEnd;
    logic burstWrite;
    logic burstAp;
    logic burst32;
    modport dev (
        input cmdValid, cmdWrite, cmdAddr, cmdData,
        input burstEnd, burstWrite, burstAp, burst32,
        output rdValid, rdData
    );
    modport ctl (
        output cmdValid, cmdWrite, cmdAddr, cmdData,
        output burstEnd, burstWrite, burstAp, burst32,
        input rdValid, rdData
    );
endinterface

// ===== verilog/dlrm_pkg.sv
// Shared constants for the latency, refresh and mode register link.
package dlrm_pkg;
    // Mode register addresses.
    localparam logic [5:0] ADDR_LAT = 6'h02;
    localparam logic [5:0] ADDR_IO = 6'h03;
    localparam logic [5:0] ADDR_RT = 6'h04;
    localparam logic [5:0] ADDR_SPC = 6'h0D;
    // io_config_mode field positions.
    localparam int IO_PUCAL = 0;
    localparam int IO_WRPST = 1;
    localparam int IO_REPAIR_PROTECTION_BIT = 2;
    localparam int IO_PULLDOWN_DRIVE_STRENGTH_LO = 3;
    localparam int IO_DBIRD = 6;
    localparam int IO_DBIWR = 7;
    // refresh_thermal_mode field positions.
    localparam int RT_SRA = 3;
    localparam int RT_REPAIR_ENTRY_BIT = 4;
    localparam int RT_OFS_LO = 5;
    localparam int RT_TUF = 7;
    localparam logic [7:0] RT_WR_MASK = 8'h78;
    // latency_mode_reg and set_point_control_reg fields.
    localparam int LAT_WLS = 6;
    localparam int SPC_WSP = 6;
    localparam int SPC_OSP = 7;
    // Reset values, rate codes, density limits and the BL32 extra count.
    localparam logic [7:0] IO_RESET = 8'h31;
    localparam logic [7:0] LAT_RESET = 8'h00;
    localparam logic [7:0] SPC_RESET = 8'h00;
    localparam logic [2:0] RATE_RESET = 3'h3;
    localparam logic [2:0] RATE_DERATE = 3'h6;
    localparam logic [2:0] RATE_BAD_LO = 3'h0;
    localparam logic [2:0] RATE_BAD_HI = 3'h7;
    localparam int DENSITY_DEFAULT = 32;
    localparam int SRA_MIN_DENSITY = 12;
    localparam logic [5:0] BL32_EXTRA = 6'h08;
    // Latency table, one entry per frequency band.
    localparam int LAT_ROWS = 7;
    localparam logic [2:0] LAT_TOP = 3'h6;
    localparam logic [7:0] RL_PLAIN [LAT_ROWS] =
        '{8'h06, 8'h0A, 8'h0E, 8'h14, 8'h18, 8'h1C, 8'h20};
    localparam logic [7:0] RL_INV [LAT_ROWS] =
        '{8'h06, 8'h0C, 8'h10, 8'h16, 8'h1C, 8'h20, 8'h24};
    localparam logic [7:0] WL_A [LAT_ROWS] =
        '{8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10};
    localparam logic [7:0] WL_B [LAT_ROWS] =
        '{8'h04, 8'h08, 8'h0C, 8'h12, 8'h16, 8'h1A, 8'h1E};
    localparam logic [5:0] NWR_TBL [LAT_ROWS] =
        '{6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22};
    localparam logic [5:0] READ_TO_PRECHARGE_COUNT_TBL [LAT_ROWS] =
        '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0A, 6'h0C, 6'h0E};
    localparam logic [10:0] FREQ_LO [LAT_ROWS] =
        '{11'h00A, 11'h10A, 11'h215, 11'h320, 11'h42A, 11'h535, 11'h640};
    localparam logic [10:0] FREQ_HI [LAT_ROWS] =
        '{11'h10A, 11'h215, 11'h320, 11'h42A, 11'h535, 11'h640, 11'h74A};
    // Controller APB register offsets and fields.
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_LAT = 8'h04;
    localparam logic [7:0] APB_FREQ = 8'h08;
    localparam logic [7:0] APB_BURST = 8'h0C;
    localparam logic [7:0] APB_REFR = 8'h10;
    localparam logic [7:0] APB_CAL = 8'h14;
    localparam int CMD_WR = 16;
    localparam int CMD_BUSY = 31;
    localparam int LAT_DBI = 3;
    localparam int LAT_WLB = 4;
    localparam int LAT_BAD = 16;
    localparam int BUR_WR = 0;
    localparam int BUR_AP = 1;
    localparam int BUR_32 = 2;
    localparam int REF_UNSAFE = 16;
    localparam logic [15:0] REFI_BASE_DEFAULT = 16'h0F3C;
endpackage
